// [rtl/led_irq_regs.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz core clock, registers reached as AHB-Lite words
// Notes:   Offsets are register indices; byte address is index times four
//
// How it works
// - Duty code 15:8, 0..198, 0.5% steps
// - Bit 7 puts second port pins serial
// - Bit 6 puts first port pins serial
// - Bits 5:3 pick frame rate 2500..40 Hz
// - Rate code 111 emits basic serial stream
// - Bits 2:1 pick LEDs on serial stream
// - Status shows source of latest interrupt
// - Bits 11:8 timestamp sources, active low
// - Timestamp bits follow their interrupt lines
// - Bits 3:0 general sources, active low
// - General bit clears on own status read
`ifndef LED_IRQ_REGS_SVH
`define LED_IRQ_REGS_SVH

// Register indices
`define IDX_LED_CTRL   8'h19
`define IDX_IRQ_SRC    8'h1D

// Control register fields
`define DUTY_MSB       15
`define DUTY_LSB       8
`define PORT1_EN_BIT   7
`define PORT0_EN_BIT   6
`define RATE_MSB       5
`define RATE_LSB       3
`define SEL_MSB        2
`define SEL_LSB        1
`define SWAP_BIT       0

// Status register fields
`define TS_MSB         11
`define TS_LSB         8
`define GEN_MSB        3
`define GEN_LSB        0

// Reset values
`define LED_CTRL_RST   16'h0000
`define SRC_IDLE       4'hF

// Duty cycle limits
`define DUTY_MAX       8'hC6
`define DUTY_STEPS     8'hC8

// Timing
`define CLK_HZ         25000000
`define CLK_PERIOD_NS  40
`define PULSE_STEP_NS  10000
`define PULSE_STEP_CYC ((`PULSE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RATE_HZ_0      2500
`define RATE_HZ_1      1000
`define RATE_HZ_2      500
`define RATE_HZ_3      250
`define RATE_HZ_4      200
`define RATE_HZ_5      125
`define RATE_HZ_6      40

`endif

// [rtl/led_irq_pkg.sv]
// Purpose: Shared types of the LED control and interrupt source block
// Assumes: Nothing beyond the header constants
// Notes:   Enum order follows the hardware field codes
package led_irq_pkg;

  typedef logic [15:0] reg16_t;

  // Frame rate field codes, last one means basic stream
  typedef enum logic [2:0] {
    RATE_2500, RATE_1000, RATE_500, RATE_250,
    RATE_200, RATE_125, RATE_40, RATE_BASIC
  } frame_rate_e;

  // Serial LED selection codes
  typedef enum logic [1:0] {
    LEDS_ALL, LEDS_2_0, LEDS_1_0, LEDS_0
  } led_sel_e;

endpackage : led_irq_pkg

// [rtl/frame_tick_gen.sv]
// Purpose: One-cycle tick at the selected serial LED frame rate
// Assumes: Period counts already derived from the clock rate
// Notes:   A rate change restarts the period so no stale count runs on
module frame_tick_gen #(
  parameter int CNT_W = 20,
  parameter logic [CNT_W-1:0] CYC0 = 20'd10000,
  parameter logic [CNT_W-1:0] CYC1 = 20'd25000,
  parameter logic [CNT_W-1:0] CYC2 = 20'd50000,
  parameter logic [CNT_W-1:0] CYC3 = 20'd100000,
  parameter logic [CNT_W-1:0] CYC4 = 20'd125000,
  parameter logic [CNT_W-1:0] CYC5 = 20'd200000,
  parameter logic [CNT_W-1:0] CYC6 = 20'd625000
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Control
  input  wire led_irq_pkg::frame_rate_e rate_i,
  // Tick out
  output logic                          tick_o
);
  import led_irq_pkg::*;

  logic [CNT_W-1:0] cnt_ff;
  frame_rate_e      rate_ff;

  // Period in clock cycles for each rate code
  function automatic logic [CNT_W-1:0] rate_cyc(input frame_rate_e r);
    unique case (r)
      RATE_2500:  rate_cyc = CYC0;
      RATE_1000:  rate_cyc = CYC1;
      RATE_500:   rate_cyc = CYC2;
      RATE_250:   rate_cyc = CYC3;
      RATE_200:   rate_cyc = CYC4;
      RATE_125:   rate_cyc = CYC5;
      RATE_40:    rate_cyc = CYC6;
      RATE_BASIC: rate_cyc = CYC0;
    endcase
  endfunction : rate_cyc

  // Down counter, reloads on wrap or rate change
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff  <= '0;
      rate_ff <= RATE_2500;
      tick_o  <= 1'b0;
    end else begin
      rate_ff <= rate_i;
      tick_o  <= 1'b0;
      if (rate_i != rate_ff || cnt_ff == '0) begin
        cnt_ff <= rate_cyc(rate_i) - 1'b1;
        tick_o <= (cnt_ff == '0) && (rate_i == rate_ff);
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule : frame_tick_gen

// [rtl/pulse_pwm.sv]
// Purpose: LED pulsing waveform with duty set in half-percent steps
// Assumes: Step enable derived from the core clock
// Notes:   Codes above the top valid code behave as the top code
`include "led_irq_regs.svh"

module pulse_pwm #(
  parameter int STEP_CYC = 250
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       enable_i,
  input  wire logic [7:0] duty_i,
  // Waveform out
  output logic            pulse_o
);
  localparam int SW = $clog2(STEP_CYC + 1);

  logic [SW-1:0] pre_ff;
  logic [7:0]    step_ff;
  logic [7:0]    duty_eff;

  // Out-of-range codes clamp to code 198 so the LED never goes fully lit
  assign duty_eff = (duty_i > `DUTY_MAX) ? `DUTY_MAX : duty_i;

  // Step prescaler and step counter over one pulsing period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_ff  <= '0;
      step_ff <= 8'h00;
    end else if (!enable_i) begin
      pre_ff  <= '0;
      step_ff <= 8'h00;
    end else if (pre_ff == SW'(STEP_CYC - 1)) begin
      pre_ff  <= '0;
      step_ff <= (step_ff == `DUTY_STEPS - 8'h01) ? 8'h00 : step_ff + 8'h01;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // Code n lights n+1 of 200 steps: 0.5% per step
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= enable_i && (step_ff <= duty_eff);
    end
  end

endmodule : pulse_pwm

// [rtl/global_led_irq_regs.sv]
// Purpose: Global LED control register and interrupt source register
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   Status bits are active low: 0 names the causing source
`include "led_irq_regs.svh"

module global_led_irq_regs #(
  parameter int PHYS           = 4,
  parameter int PULSE_STEP_CYC = `PULSE_STEP_CYC,
  parameter int FRAME_CYC_0    = `CLK_HZ / `RATE_HZ_0,
  parameter int FRAME_CYC_1    = `CLK_HZ / `RATE_HZ_1,
  parameter int FRAME_CYC_2    = `CLK_HZ / `RATE_HZ_2,
  parameter int FRAME_CYC_3    = `CLK_HZ / `RATE_HZ_3,
  parameter int FRAME_CYC_4    = `CLK_HZ / `RATE_HZ_4,
  parameter int FRAME_CYC_5    = `CLK_HZ / `RATE_HZ_5,
  parameter int FRAME_CYC_6    = `CLK_HZ / `RATE_HZ_6
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     sys_rst_i,
  // AHB-Lite slave
  input  wire logic                     hsel_i,
  input  wire logic [31:0]              haddr_i,
  input  wire logic [1:0]               htrans_i,
  input  wire logic                     hwrite_i,
  input  wire logic [2:0]               hsize_i,
  input  wire logic                     hready_i,
  input  wire logic [31:0]              hwdata_i,
  output logic [31:0]                   hrdata_o,
  output logic                          hreadyout_o,
  output logic                          hresp_o,
  // Interrupt sources from the PHYs
  input  wire logic [PHYS-1:0]          ts_irq_i,
  input  wire logic [PHYS-1:0]          phy_irq_i,
  input  wire logic [PHYS-1:0]          phy_stat_rd_i,
  // Pulsing enable from the LED behaviour register
  input  wire logic                     pulse_en_i,
  // LED control outputs
  output logic [7:0]                    led_duty_o,
  output logic                          port1_serial_en_o,
  output logic                          port0_serial_en_o,
  output led_irq_pkg::frame_rate_e      frame_rate_o,
  output logic                          basic_stream_o,
  output logic                          frame_tick_o,
  output led_irq_pkg::led_sel_e         led_sel_o,
  output logic [3:0]                    led_mask_o,
  output logic                          led_swap_o,
  output logic                          led_pulse_o,
  // Source indications as seen in the status register
  output logic [PHYS-1:0]               ts_src_n_o,
  output logic [PHYS-1:0]               gen_src_n_o
);
  import led_irq_pkg::*;

  localparam int FCW = 20;

  // Bus phase tracking
  logic        wr_pend_ff;
  logic        rd_sel_ff;
  logic [7:0]  wr_idx_ff;
  logic        addr_ok;
  logic [7:0]  addr_idx;
  logic        take;

  // Register state
  reg16_t      led_ctrl_ff;
  reg16_t      nxt_led_ctrl;
  logic [PHYS-1:0] ts_src_ff;
  logic [PHYS-1:0] gen_src_ff;
  logic [PHYS-1:0] nxt_gen_src;
  reg16_t      status_word;
  reg16_t      rd_word;

  // Fields of the control register
  logic [7:0]  fld_duty;
  frame_rate_e fld_rate;
  led_sel_e    fld_sel;

  // Index of a word address; upper bits must be zero to hit a register
  function automatic logic is_reg(input logic [31:0] a, input logic [7:0] idx);
    is_reg = (a[31:10] == 22'h000000) && (a[9:2] == idx);
  endfunction : is_reg

  // LEDs kept on the serial stream for a selection code
  function automatic logic [3:0] sel_mask(input led_sel_e s);
    unique case (s)
      LEDS_ALL: sel_mask = 4'hF;
      LEDS_2_0: sel_mask = 4'h7;
      LEDS_1_0: sel_mask = 4'h3;
      LEDS_0:   sel_mask = 4'h1;
    endcase
  endfunction : sel_mask

  // Address phase is accepted only while the bus is ready
  assign take     = hsel_i && htrans_i[1] && hready_i;
  assign addr_idx = haddr_i[9:2];
  assign addr_ok  = (haddr_i[31:10] == 22'h000000);

  // Remember the write address until its data phase
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end else if (hready_i) begin
      wr_pend_ff <= take && hwrite_i && addr_ok;
      wr_idx_ff  <= addr_idx;
    end
  end

  // Read data phase flag; read data fall back to zero once it ends
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_sel_ff <= 1'b0;
    end else if (hready_i) begin
      rd_sel_ff <= take && !hwrite_i;
    end
  end

  // Control register next value; only the control word is writable
  always_comb begin
    nxt_led_ctrl = led_ctrl_ff;
    if (wr_pend_ff && wr_idx_ff == `IDX_LED_CTRL) begin
      nxt_led_ctrl = hwdata_i[15:0];
    end
    // Writes to the status word fall through untouched
  end

  // Control register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      led_ctrl_ff <= `LED_CTRL_RST;
    end else begin
      led_ctrl_ff <= nxt_led_ctrl;
    end
  end

  // Field views of the control register
  assign fld_duty = led_ctrl_ff[`DUTY_MSB:`DUTY_LSB];
  assign fld_rate = frame_rate_e'(led_ctrl_ff[`RATE_MSB:`RATE_LSB]);
  assign fld_sel  = led_sel_e'(led_ctrl_ff[`SEL_MSB:`SEL_LSB]);

  // Timestamp bits follow their lines, low while asserted
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ts_src_ff <= `SRC_IDLE;
    end else begin
      ts_src_ff <= ~ts_irq_i;
    end
  end

  // General source bits: event drives low, own status read restores.
  // An event in the same cycle as the read wins, so nothing is lost.
  generate
    for (genvar i = 0; i < PHYS; i++) begin : g_gen_src
      always_comb begin
        if (phy_irq_i[i]) begin
          nxt_gen_src[i] = 1'b0;
        end else if (phy_stat_rd_i[i]) begin
          nxt_gen_src[i] = 1'b1;
        end else begin
          nxt_gen_src[i] = gen_src_ff[i];
        end
      end
    end
  endgenerate

  // General source register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gen_src_ff <= `SRC_IDLE;
    end else begin
      gen_src_ff <= nxt_gen_src;
    end
  end

  // Status word; reserved bits read zero
  always_comb begin
    status_word = 16'h0000;
    status_word[`TS_MSB:`TS_LSB]   = ts_src_ff;
    status_word[`GEN_MSB:`GEN_LSB] = gen_src_ff;
  end

  // Read mux uses the next control value so a write then read
  // back to back returns the freshly written word
  always_comb begin
    rd_word = 16'h0000;
    if (is_reg(haddr_i, `IDX_LED_CTRL)) begin
      rd_word = nxt_led_ctrl;
    end else if (is_reg(haddr_i, `IDX_IRQ_SRC)) begin
      rd_word = status_word;
    end
  end

  // Read data registered at the address phase; unmapped reads give zero
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= {16'h0000, rd_word};
    end else if (hready_i && rd_sel_ff) begin
      hrdata_o <= 32'h00000000;
    end
  end

  // Zero wait states and always OKAY; no transfer can fault here
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // LED control outputs from the register fields
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      led_duty_o        <= 8'h00;
      port1_serial_en_o <= 1'b0;
      port0_serial_en_o <= 1'b0;
      frame_rate_o      <= RATE_2500;
      basic_stream_o    <= 1'b0;
      led_sel_o         <= LEDS_ALL;
      led_mask_o        <= 4'hF;
      led_swap_o        <= 1'b0;
    end else begin
      led_duty_o        <= fld_duty;
      port1_serial_en_o <= led_ctrl_ff[`PORT1_EN_BIT];
      port0_serial_en_o <= led_ctrl_ff[`PORT0_EN_BIT];
      frame_rate_o      <= fld_rate;
      basic_stream_o    <= (fld_rate == RATE_BASIC);
      led_sel_o         <= fld_sel;
      led_mask_o        <= sel_mask(fld_sel);
      led_swap_o        <= led_ctrl_ff[`SWAP_BIT];
    end
  end

  // Source indications mirrored for the interrupt pin logic
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ts_src_n_o  <= `SRC_IDLE;
      gen_src_n_o <= `SRC_IDLE;
    end else begin
      ts_src_n_o  <= ts_src_ff;
      gen_src_n_o <= gen_src_ff;
    end
  end

  // Frame tick at every rate code; the basic stream code ticks at the 2500 Hz period
  frame_tick_gen #(
    .CNT_W (FCW),
    .CYC0  (FCW'(FRAME_CYC_0)),
    .CYC1  (FCW'(FRAME_CYC_1)),
    .CYC2  (FCW'(FRAME_CYC_2)),
    .CYC3  (FCW'(FRAME_CYC_3)),
    .CYC4  (FCW'(FRAME_CYC_4)),
    .CYC5  (FCW'(FRAME_CYC_5)),
    .CYC6  (FCW'(FRAME_CYC_6))
  ) u_frame (
    .clk_i  (core_clk_i),
    .rst_i  (sys_rst_i),
    .rate_i (fld_rate),
    .tick_o (frame_tick_o)
  );

  // Pulsing waveform, active only while pulsing is enabled
  pulse_pwm #(
    .STEP_CYC (PULSE_STEP_CYC)
  ) u_pulse (
    .clk_i    (core_clk_i),
    .rst_i    (sys_rst_i),
    .enable_i (pulse_en_i),
    .duty_i   (fld_duty),
    .pulse_o  (led_pulse_o)
  );

endmodule : global_led_irq_regs

// [verif/led_irq_chk_sva.sv]
// Purpose: Port checks of the LED control and source block
// Assumes: Zero wait bus, source outputs two cycles behind inputs
// Notes:   Bound to the design top at the foot
`include "led_irq_regs.svh"
module led_irq_chk #(
  parameter int PHYS = 4
) (
  // Clock, reset and bus
  input wire logic                 core_clk_i,
  input wire logic                 sys_rst_i,
  input wire logic                 hsel_i,
  input wire logic [31:0]          haddr_i,
  input wire logic [1:0]           htrans_i,
  input wire logic                 hwrite_i,
  input wire logic                 hready_i,
  input wire logic [31:0]          hwdata_i,
  input wire logic [31:0]          hrdata_o,
  input wire logic                 hreadyout_o,
  input wire logic                 hresp_o,
  // Sources
  input wire logic [PHYS-1:0]      ts_irq_i,
  input wire logic [PHYS-1:0]      phy_irq_i,
  input wire logic [PHYS-1:0]      phy_stat_rd_i,
  input wire logic [PHYS-1:0]      ts_src_n_o,
  input wire logic [PHYS-1:0]      gen_src_n_o,
  // LED control
  input wire logic [7:0]           led_duty_o,
  input wire logic                 port1_serial_en_o,
  input wire logic                 port0_serial_en_o,
  input wire led_irq_pkg::frame_rate_e frame_rate_o,
  input wire logic                 basic_stream_o,
  input wire logic                 frame_tick_o,
  input wire led_irq_pkg::led_sel_e led_sel_o,
  input wire logic [3:0]           led_mask_o,
  input wire logic                 led_swap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import led_irq_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Accepted address phases; upper address bits must be clear
  logic acc;
  logic wr_ctl;
  logic rd_st;
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign wr_ctl = acc & hwrite_i & (haddr_i == {22'h000000, `IDX_LED_CTRL, 2'h0});
  assign rd_st = acc & !hwrite_i & (haddr_i == {22'h000000, `IDX_IRQ_SRC, 2'h0});

  bus_ok_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not OKAY");
  // Data phase lands in the register, outputs follow one edge later
  ctrl_write_a: assert property (wr_ctl |-> ##3 {led_duty_o, port1_serial_en_o,
    port0_serial_en_o, frame_rate_o, led_sel_o, led_swap_o} == $past(hwdata_i[15:0], 2))
    else $error("control outputs differ from written word");
  basic_mode_a: assert property (basic_stream_o == (frame_rate_o == RATE_BASIC))
    else $error("basic stream flag wrong");
  led_mask_a: assert property (led_mask_o == (4'hF >> led_sel_o))
    else $error("LED mask wrong for selection");
  ts_follow_a: assert property (ts_src_n_o == ~$past(ts_irq_i, 2))
    else $error("timestamp source does not follow its line");
  gen_set_a: assert property ((gen_src_n_o & $past(phy_irq_i, 2)) == '0)
    else $error("general source not shown");
  gen_clear_a: assert property ((~gen_src_n_o & $past(phy_stat_rd_i, 2)
    & ~$past(phy_irq_i, 2)) == '0) else $error("general source not cleared");
  gen_hold_a: assert property ((gen_src_n_o & ~$past(gen_src_n_o) &
    ~($past(phy_stat_rd_i, 2) & ~$past(phy_irq_i, 2))) == '0)
    else $error("general source cleared without own read");
  stat_read_a: assert property (rd_st |=> hrdata_o ==
    {20'h00000, ts_src_n_o, 4'h0, gen_src_n_o}) else $error("status read wrong");
  tick_pulse_a: assert property (frame_tick_o |=> !frame_tick_o)
    else $error("frame tick longer than one cycle");
endmodule : led_irq_chk

bind global_led_irq_regs led_irq_chk #(.PHYS(PHYS)) led_irq_chk_inst (.core_clk_i,
  .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .ts_irq_i, .phy_irq_i, .phy_stat_rd_i, .ts_src_n_o,
  .gen_src_n_o, .led_duty_o, .port1_serial_en_o, .port0_serial_en_o, .frame_rate_o,
  .basic_stream_o, .frame_tick_o, .led_sel_o, .led_mask_o, .led_swap_o);

// [verif/irq_src_model.sv]
// Purpose: PHY interrupt lines and own status reads by software
// Assumes: Four PHYs, changes made right after a clock edge
// Notes:   Read delay argument lets software answer fast or slow
module irq_src_model (
  // Clock
  input  wire logic  clk_i,
  // Lines toward the block
  output logic [3:0] ts_irq_o,
  output logic [3:0] phy_irq_o,
  output logic [3:0] stat_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines from time zero
  initial begin
    ts_irq_o = 4'h0;
    phy_irq_o = 4'h0;
    stat_rd_o = 4'h0;
  end
  // Timestamp lines are plain levels
  task automatic set_ts(input logic [3:0] v);
    @(posedge clk_i);
    ts_irq_o <= v;
  endtask : set_ts
  // General interrupt held for len cycles
  task automatic pulse_gen(input int k, input int len);
    @(posedge clk_i);
    phy_irq_o[k] <= 1'b1;
    repeat (len) @(posedge clk_i);
    phy_irq_o[k] <= 1'b0;
  endtask : pulse_gen
  // Only this read clears the general indication
  task automatic read_own(input int k, input int dly);
    repeat (dly) @(posedge clk_i);
    stat_rd_o[k] <= 1'b1;
    @(posedge clk_i);
    stat_rd_o[k] <= 1'b0;
  endtask : read_own
endmodule : irq_src_model

// [verif/global_led_irq_regs_tb.sv]
// Purpose: Register, LED timing and source checks over AHB-Lite
// Assumes: Short frame and pulse counts set at the instance
// Notes:   One idle cycle between transfers keeps the driver simple
`include "led_irq_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module global_led_irq_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import led_irq_pkg::*;
  localparam logic [7:0] CTRL = `IDX_LED_CTRL;
  localparam logic [7:0] STAT = `IDX_IRQ_SRC;
  localparam int FC[8] = '{20, 30, 40, 50, 60, 70, 80, 20};
  logic core_clk_i, sys_rst_i, hsel_i, hwrite_i, hreadyout_o, pulse_en_i;
  logic p1_en, p0_en, basic, tick, pulse;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i;
  logic [3:0] ts_irq, phy_irq, stat_rd, ts_src_n;
  led_sel_e sel;
  int n_fail, n_compared, n, h, c;
  logic [7:0] duty[5] = '{8'h00, 8'h63, 8'hC6, 8'hFF, 8'h63};

  global_led_irq_regs #(.PULSE_STEP_CYC(2), .FRAME_CYC_0(FC[0]), .FRAME_CYC_1(FC[1]),
    .FRAME_CYC_2(FC[2]), .FRAME_CYC_3(FC[3]), .FRAME_CYC_4(FC[4]), .FRAME_CYC_5(FC[5]),
    .FRAME_CYC_6(FC[6])) global_led_irq_regs_inst (.core_clk_i, .sys_rst_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i,
    .hrdata_o, .hreadyout_o, .hresp_o(), .ts_irq_i(ts_irq), .phy_irq_i(phy_irq),
    .phy_stat_rd_i(stat_rd), .pulse_en_i, .led_duty_o(), .port1_serial_en_o(p1_en),
    .port0_serial_en_o(p0_en), .frame_rate_o(), .basic_stream_o(basic),
    .frame_tick_o(tick), .led_sel_o(sel), .led_mask_o(), .led_swap_o(),
    .led_pulse_o(pulse), .ts_src_n_o(ts_src_n), .gen_src_n_o());
  irq_src_model irq_src_model_inst (.clk_i(core_clk_i), .ts_irq_o(ts_irq),
    .phy_irq_o(phy_irq), .stat_rd_o(stat_rd));

  // 40 ns clock
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // Single word transfer; each phase lasts until ready is seen
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rv);
    @(posedge core_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {22'h000000, idx, 2'h0};
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    rv = hrdata_o;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, idx, d, v);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] v;
    xfer(1'b0, idx, 32'h00000000, v);
    `CHK(nm, e, v)
  endtask : rdchk
  // Cycles up to and including the next frame tick
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (tick !== 1'b1 && k < 1000);
  endtask : wait_tick
  task automatic results;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    {hsel_i, hwrite_i, pulse_en_i, htrans_i, haddr_i, hwdata_i} = '0;
    sys_rst_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rdchk("ctrl reset", CTRL, 32'h00000000);
    rdchk("stat idle", STAT, 32'h00000F0F);
    wr(CTRL, 32'hFFFFC6FF);
    rdchk("ctrl all", CTRL, 32'h0000C6FF);
    `CHK("port1 on", 1'b1, p1_en)
    `CHK("sel led0", LEDS_0, sel)
    wr(CTRL, 32'h00000042);
    rdchk("ctrl port0", CTRL, 32'h00000042);
    `CHK("port1 off", 1'b0, p1_en)
    `CHK("port0 on", 1'b1, p0_en)
    `CHK("sel 2 to 0", LEDS_2_0, sel)
    wr(CTRL, 32'h00000084);
    rdchk("ctrl port1", CTRL, 32'h00000084);
    `CHK("port1 again", 1'b1, p1_en)
    `CHK("port0 off", 1'b0, p0_en)
    `CHK("sel 1 to 0", LEDS_1_0, sel)
    wr(STAT, 32'hFFFFFFFF);
    rdchk("stat write", STAT, 32'h00000F0F);
    rdchk("unmapped", 8'h20, 32'h00000000);
    // Every rate code; period measured between two whole frames
    for (int k = 0; k < 8; k++) begin
      wr(CTRL, k << 3);
      wait_tick(n);
      wait_tick(n);
      `CHK("frame period", FC[k], n)
      `CHK("basic", k == 7, basic)
    end
    // Pulse duty over one 400 cycle period, last case with pulsing off
    for (int i = 0; i < 5; i++) begin
      pulse_en_i <= (i < 4);
      wr(CTRL, {16'h0000, duty[i], 8'h00});
      repeat (400) @(posedge core_clk_i);
      h = 0;
      repeat (400) @(posedge core_clk_i) h += int'(pulse === 1'b1);
      c = (i < 4) ? ((duty[i] > 8'hC6 ? 198 : duty[i]) + 1) * 2 : 0;
      `CHK("pulse high", c, h)
    end
    irq_src_model_inst.set_ts(4'hA);
    repeat (3) @(posedge core_clk_i);
    `CHK("ts out", 4'h5, ts_src_n)
    rdchk("stat ts", STAT, 32'h0000050F);
    irq_src_model_inst.set_ts(4'h0);
    repeat (3) @(posedge core_clk_i);
    rdchk("ts cleared", STAT, 32'h00000F0F);
    irq_src_model_inst.pulse_gen(2, 1);
    repeat (3) @(posedge core_clk_i);
    rdchk("gen set", STAT, 32'h00000F0B);
    rdchk("gen kept", STAT, 32'h00000F0B);
    irq_src_model_inst.read_own(2, 4);
    repeat (3) @(posedge core_clk_i);
    rdchk("gen cleared", STAT, 32'h00000F0F);
    results();
  end
  // Watchdog, about four times the expected run
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    results();
  end
endmodule : global_led_irq_regs_tb
